// File: verilog/lei_pkg.sv
// constants for the line interface error insert and interrupt slice
// assumes a 25 MHz system clock and 32-bit avalon-mm register access
package lei_pkg;
  localparam int CLK_HZ = 25_000_000;
  localparam int LOOP_TIME_MS = 5000;
  localparam int LOOP_CYCLES = CLK_HZ / 1000 * LOOP_TIME_MS;
  localparam int DMO_BITS = 128;
  localparam int QRSS_LEN = 20;
  localparam int QRSS_TAP = 17;
  localparam int LOOP_UP_LEN = 5;
  localparam int LOOP_DN_LEN = 3;
  localparam int SYNC_PINS = 4;
  localparam int PIN_TX_CLK = 0;
  localparam int PIN_TX_DATA = 1;
  localparam int PIN_RX_CLK = 2;
  localparam int PIN_RX_DATA = 3;
  // byte offsets
  localparam logic [7:0] OFF_INSERT = 8'h00;
  localparam logic [7:0] OFF_IRQ_EN = 8'h04;
  localparam logic [7:0] OFF_EVENT = 8'h08;
  localparam logic [7:0] OFF_LIVE = 8'h0c;
  localparam logic [7:0] OFF_CFG = 8'h10;
  // insert control fields
  localparam int BIT_BPV = 2;
  localparam int BIT_BER = 1;
  localparam logic [7:0] INSERT_MASK = 8'h07;
  localparam logic [7:0] INSERT_RESET = 8'h00;
  // interrupt enable, event and live status fields
  localparam int BIT_DMO = 6;
  localparam int BIT_FLS = 5;
  localparam int BIT_LCV = 4;
  localparam int BIT_LOOP_CODE_DETECTED = 3;
  localparam int BIT_AIS = 2;
  localparam logic [7:0] IRQ_MASK = 8'h7c;
  localparam logic [7:0] IRQ_EN_RESET = 8'h00;
  // configuration fields
  localparam int CFG_TEST_LSB = 0;
  localparam int CFG_SR_LIU = 3;
  localparam int CFG_SR_FRM = 4;
  localparam int CFG_LOOP_DN = 5;
  localparam logic [7:0] CFG_MASK = 8'h3f;
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam logic [2:0] TEST_QRSS = 3'h4;
endpackage : lei_pkg

// File: verilog/lei_tx_if.sv
// signals between the register side and the transmit insert path
// assumes both ends run on the one system clock
`timescale 1ns/1ns
interface lei_tx_if;
  logic tx_edge;
  logic data_in;
  logic qrss_mode;
  logic single_rail;
  logic bpv_ctl;
  logic ber_ctl;
  logic pos;
  logic neg;
  logic driver_monitor_alarm;
  modport ctl (output tx_edge, data_in, qrss_mode, single_rail, bpv_ctl,
    ber_ctl, input pos, neg, driver_monitor_alarm);
  modport tx (input tx_edge, data_in, qrss_mode, single_rail, bpv_ctl,
    ber_ctl, output pos, neg, driver_monitor_alarm);
endinterface : lei_tx_if

// File: verilog/lei_tx_insert.sv
// transmit path: qrss source, error insert, ami coding, driver monitor
// assumes tx_edge pulses one system cycle per tx line clock rise
`timescale 1ns/1ns
module lei_tx_insert (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // transmit side
  lei_tx_if.tx t
);
  logic bpv_samp_reg;
  logic ber_samp_reg;
  logic bpv_pend_reg;
  logic ber_pend_reg;
  logic last_pol_reg;
  logic pos_reg;
  logic neg_reg;
  logic dmo_reg;
  logic [7:0] dmo_cnt_reg;
  logic [lei_pkg::QRSS_LEN-1:0] lfsr_reg;
  logic bpv_rise;
  logic ber_rise;
  logic qbit;
  logic data_bit;
  logic pol;

  assign bpv_rise = t.bpv_ctl & ~bpv_samp_reg;
  assign ber_rise = t.ber_ctl & ~ber_samp_reg;
  assign qbit = lfsr_reg[lei_pkg::QRSS_LEN-1] ^ lfsr_reg[lei_pkg::QRSS_TAP-1];
  assign data_bit = t.qrss_mode ? (qbit ^ ber_pend_reg) : t.data_in;
  assign pol = bpv_pend_reg ? last_pol_reg : ~last_pol_reg;
  assign t.pos = pos_reg;
  assign t.neg = neg_reg;
  assign t.driver_monitor_alarm = dmo_reg;

  // control bits sampled only at tx clock rise
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      bpv_samp_reg <= 1'b0;
      ber_samp_reg <= 1'b0;
    end else if (t.tx_edge) begin
      bpv_samp_reg <= t.bpv_ctl;
      ber_samp_reg <= t.ber_ctl;
    end
  end

  // pending violation, consumed by the next mark
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      bpv_pend_reg <= 1'b0;
    end else if (t.tx_edge) begin
      bpv_pend_reg <= (bpv_pend_reg & ~data_bit) |
        (bpv_rise & (t.qrss_mode | t.single_rail));
    end
  end

  // pending bit error, consumed on the next qrss bit
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ber_pend_reg <= 1'b0;
    end else if (t.tx_edge) begin
      ber_pend_reg <= (ber_pend_reg & ~t.qrss_mode) |
        (ber_rise & t.qrss_mode);
    end
  end

  // qrss generator
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      lfsr_reg <= '1;
    end else if (t.tx_edge && t.qrss_mode) begin
      lfsr_reg <= {lfsr_reg[lei_pkg::QRSS_LEN-2:0], qbit};
    end
  end

  // ami line coder
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pos_reg <= 1'b0;
      neg_reg <= 1'b0;
      last_pol_reg <= 1'b0;
    end else if (t.tx_edge) begin
      pos_reg <= data_bit & pol;
      neg_reg <= data_bit & ~pol;
      if (data_bit) begin
        last_pol_reg <= pol;
      end
    end
  end

  // driver monitor, counts bit periods with no pulse
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      dmo_cnt_reg <= 8'h00;
      dmo_reg <= 1'b0;
    end else if (t.tx_edge) begin
      if (data_bit) begin
        dmo_cnt_reg <= 8'h00;
        dmo_reg <= 1'b0;
      end else if (dmo_cnt_reg != 8'(lei_pkg::DMO_BITS)) begin
        dmo_cnt_reg <= dmo_cnt_reg + 8'h01;
        dmo_reg <= (dmo_cnt_reg == 8'(lei_pkg::DMO_BITS - 1));
      end
    end
  end

  AST_BPV_SAME_POL: assert property (@(posedge clock) disable iff (rst)
    (t.tx_edge && bpv_pend_reg && data_bit) |=>
    (pos_reg == $past(last_pol_reg)) && (pos_reg != neg_reg))
    else $error("violation not sent with repeated polarity");
  AST_BPV_NEEDS_MODE: assert property (@(posedge clock) disable iff (rst)
    (t.tx_edge && !bpv_pend_reg && !t.qrss_mode && !t.single_rail) |=>
    !bpv_pend_reg)
    else $error("violation armed outside qrss or single rail");
  AST_SAMPLE_ON_EDGE: assert property (@(posedge clock) disable iff (rst)
    !t.tx_edge |=> $stable(bpv_samp_reg) && $stable(ber_samp_reg))
    else $error("insert bits sampled without tx clock rise");
  AST_BER_QRSS_ONLY: assert property (@(posedge clock) disable iff (rst)
    (t.tx_edge && !t.qrss_mode) |=> !ber_pend_reg)
    else $error("bit error pending outside qrss mode");
  AST_DMO_SET: assert property (@(posedge clock) disable iff (rst)
    (t.tx_edge && !data_bit &&
    dmo_cnt_reg == 8'(lei_pkg::DMO_BITS - 1)) |=> dmo_reg)
    else $error("driver monitor not raised after 128 idle bits");
  AST_DMO_CLEAR: assert property (@(posedge clock) disable iff (rst)
    (t.tx_edge && data_bit) |=> !dmo_reg && (pos_reg || neg_reg))
    else $error("driver monitor not cleared on activity");
  COV_BPV: cover property (@(posedge clock) disable iff (rst)
    t.tx_edge && bpv_pend_reg && data_bit);
  COV_BER: cover property (@(posedge clock) disable iff (rst)
    t.tx_edge && ber_pend_reg && t.qrss_mode);
endmodule : lei_tx_insert

// File: verilog/lei_loop_det.sv
// network loop code detector on the receive bit stream
// assumes bit_strobe pulses one system cycle per received bit
`timescale 1ns/1ns
module lei_loop_det #(
  parameter int unsigned LOOP_CYCLES = lei_pkg::LOOP_CYCLES
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // receive bits
  input wire logic bit_strobe,
  input wire logic rx_bit,
  input wire logic loop_down_sel,
  // status
  output logic detected
);
  logic [lei_pkg::LOOP_UP_LEN-1:0] hist_reg;
  logic run_reg;
  logic sel_reg;
  logic [31:0] cnt_reg;
  logic ok;

  always_comb begin
    if (loop_down_sel) begin
      ok = (rx_bit == hist_reg[lei_pkg::LOOP_DN_LEN-1]) &&
        ($countones(hist_reg[lei_pkg::LOOP_DN_LEN-1:0]) == 1);
    end else begin
      ok = (rx_bit == hist_reg[lei_pkg::LOOP_UP_LEN-1]) &&
        ($countones(hist_reg) == 1);
    end
  end

  // pattern tracking per received bit
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      hist_reg <= '0;
      run_reg <= 1'b0;
      sel_reg <= 1'b0;
    end else begin
      sel_reg <= loop_down_sel;
      if (sel_reg != loop_down_sel) begin
        run_reg <= 1'b0;
      end else if (bit_strobe) begin
        hist_reg <= {hist_reg[lei_pkg::LOOP_UP_LEN-2:0], rx_bit};
        run_reg <= ok;
      end
    end
  end

  // persistence timer
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cnt_reg <= 32'h0;
      detected <= 1'b0;
    end else if (!run_reg) begin
      cnt_reg <= 32'h0;
      detected <= 1'b0;
    end else if (cnt_reg != LOOP_CYCLES) begin
      cnt_reg <= cnt_reg + 32'h1;
    end else begin
      detected <= 1'b1;
    end
  end

  AST_LOOP_SET: assert property (@(posedge clock) disable iff (rst)
    (run_reg && cnt_reg == LOOP_CYCLES) |=> detected)
    else $error("loop code not declared after hold time");
  AST_LOOP_EARLY: assert property (@(posedge clock) disable iff (rst)
    (cnt_reg < LOOP_CYCLES) |-> !detected)
    else $error("loop code declared too early");
endmodule : lei_loop_det

// File: verilog/lei_top.sv
// line interface error insert and interrupt enable slice, one channel
// assumes an avalon-mm master on the system clock; line pins asynchronous
// Notes on behaviour
// - rising bpv bit inserts one violation
// - violation in qrss or single-rail data
// - insert bits sampled on tx clock rise
// - rising error bit flips one qrss bit
// - driver monitor change interrupts both ways
// - fifo limit interrupt when enabled
// - violation enable allows or masks interrupts
// - loop code start and stop interrupt
// - ais enable allows or masks interrupts
// - monitor alarm after 128 idle bits
// - loop code held five seconds sets status
// - interrupts only with both ends single-rail
`timescale 1ns/1ns
module lei_top #(
  parameter int unsigned LOOP_CYCLES = lei_pkg::LOOP_CYCLES
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // avalon-mm slave
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // line pins
  input wire logic tx_line_clock,
  input wire logic tx_data_in,
  input wire logic rx_line_clock,
  input wire logic rx_data,
  output logic tx_pos,
  output logic tx_neg,
  // alarm inputs from neighbouring detectors
  input wire logic fifo_limit_in,
  input wire logic line_violation_in,
  input wire logic ais_detect_in,
  // interrupt
  output logic irq
);
  lei_tx_if txi ();

  logic [31:0] readdata_reg;
  logic waitrequest_reg;
  logic irq_reg;
  logic [7:0] insert_reg;
  logic [7:0] irq_en_reg;
  logic [7:0] event_reg;
  logic [7:0] cfg_reg;
  logic [7:0] prev_reg;
  logic [lei_pkg::SYNC_PINS-1:0] s1_reg;
  logic [lei_pkg::SYNC_PINS-1:0] s2_reg;
  logic [lei_pkg::SYNC_PINS-1:0] s3_reg;
  logic [lei_pkg::SYNC_PINS-1:0] lvl_reg;
  logic [lei_pkg::SYNC_PINS-1:0] lvl_next;
  logic [lei_pkg::SYNC_PINS-1:0] pins;
  logic [7:0] live;
  logic [7:0] event_set;
  logic [7:0] event_next;
  logic [7:0] rd_mux;
  logic wr_go;
  logic sr_ok;
  logic rx_edge;
  logic loop_code_detected;

  assign pins = {rx_data, rx_line_clock, tx_data_in, tx_line_clock};

  // three-stage pin synchronisers with agreement filter
  genvar gi;
  generate
    for (gi = 0; gi < lei_pkg::SYNC_PINS; gi++) begin : g_sync
      always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
          s1_reg[gi] <= 1'b0;
          s2_reg[gi] <= 1'b0;
          s3_reg[gi] <= 1'b0;
          lvl_reg[gi] <= 1'b0;
        end else begin
          s1_reg[gi] <= pins[gi];
          s2_reg[gi] <= s1_reg[gi];
          s3_reg[gi] <= s2_reg[gi];
          lvl_reg[gi] <= lvl_next[gi];
        end
      end
      assign lvl_next[gi] = (s2_reg[gi] == s3_reg[gi]) ?
        s3_reg[gi] : lvl_reg[gi];
    end
  endgenerate

  assign rx_edge = lvl_next[lei_pkg::PIN_RX_CLK] &
    ~lvl_reg[lei_pkg::PIN_RX_CLK];
  assign txi.tx_edge = lvl_next[lei_pkg::PIN_TX_CLK] &
    ~lvl_reg[lei_pkg::PIN_TX_CLK];
  assign txi.data_in = lvl_reg[lei_pkg::PIN_TX_DATA];
  assign txi.qrss_mode = (cfg_reg[lei_pkg::CFG_TEST_LSB +: 3] ==
    lei_pkg::TEST_QRSS);
  assign txi.single_rail = cfg_reg[lei_pkg::CFG_SR_LIU];
  assign txi.bpv_ctl = insert_reg[lei_pkg::BIT_BPV];
  assign txi.ber_ctl = insert_reg[lei_pkg::BIT_BER];

  lei_tx_insert u_tx (
    .clock(clock),
    .rst(rst),
    .t(txi)
  );

  lei_loop_det #(
    .LOOP_CYCLES(LOOP_CYCLES)
  ) u_loop (
    .clock(clock),
    .rst(rst),
    .bit_strobe(rx_edge),
    .rx_bit(lvl_reg[lei_pkg::PIN_RX_DATA]),
    .loop_down_sel(cfg_reg[lei_pkg::CFG_LOOP_DN]),
    .detected(loop_code_detected)
  );

  assign tx_pos = txi.pos;
  assign tx_neg = txi.neg;

  // live alarm levels and their events
  assign sr_ok = cfg_reg[lei_pkg::CFG_SR_LIU] &
    cfg_reg[lei_pkg::CFG_SR_FRM];
  always_comb begin
    live = 8'h00;
    live[lei_pkg::BIT_DMO] = txi.driver_monitor_alarm;
    live[lei_pkg::BIT_FLS] = fifo_limit_in;
    live[lei_pkg::BIT_LCV] = line_violation_in;
    live[lei_pkg::BIT_LOOP_CODE_DETECTED] = loop_code_detected;
    live[lei_pkg::BIT_AIS] = ais_detect_in;
    event_set = 8'h00;
    event_set[lei_pkg::BIT_DMO] = live[lei_pkg::BIT_DMO] ^
      prev_reg[lei_pkg::BIT_DMO];
    event_set[lei_pkg::BIT_FLS] = live[lei_pkg::BIT_FLS] &
      ~prev_reg[lei_pkg::BIT_FLS];
    event_set[lei_pkg::BIT_LCV] = live[lei_pkg::BIT_LCV] &
      ~prev_reg[lei_pkg::BIT_LCV];
    event_set[lei_pkg::BIT_LOOP_CODE_DETECTED] = live[lei_pkg::BIT_LOOP_CODE_DETECTED] ^
      prev_reg[lei_pkg::BIT_LOOP_CODE_DETECTED];
    event_set[lei_pkg::BIT_AIS] = live[lei_pkg::BIT_AIS] &
      ~prev_reg[lei_pkg::BIT_AIS];
    event_set = event_set & {8{sr_ok}};
    event_next = event_reg;
    if (wr_go && avs_address == lei_pkg::OFF_EVENT) begin
      event_next = event_next & ~avs_writedata[7:0];
    end
    event_next = event_next | event_set;
  end

  assign wr_go = avs_write & ~waitrequest_reg & avs_byteenable[0];

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      prev_reg <= 8'h00;
    end else begin
      prev_reg <= live;
    end
  end

  // sticky events, set wins over a same-cycle clear
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      event_reg <= 8'h00;
    end else begin
      event_reg <= event_next;
    end
  end

  // software registers
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      insert_reg <= lei_pkg::INSERT_RESET;
      irq_en_reg <= lei_pkg::IRQ_EN_RESET;
      cfg_reg <= lei_pkg::CFG_RESET;
    end else if (wr_go) begin
      case (avs_address)
        lei_pkg::OFF_INSERT: begin
          insert_reg <= avs_writedata[7:0] & lei_pkg::INSERT_MASK;
        end
        lei_pkg::OFF_IRQ_EN: begin
          irq_en_reg <= avs_writedata[7:0] & lei_pkg::IRQ_MASK;
        end
        lei_pkg::OFF_CFG: begin
          cfg_reg <= avs_writedata[7:0] & lei_pkg::CFG_MASK;
        end
        default: begin
        end
      endcase
    end
  end

  // read mux
  always_comb begin
    case (avs_address)
      lei_pkg::OFF_INSERT: rd_mux = insert_reg;
      lei_pkg::OFF_IRQ_EN: rd_mux = irq_en_reg;
      lei_pkg::OFF_EVENT: rd_mux = event_reg;
      lei_pkg::OFF_LIVE: rd_mux = live;
      lei_pkg::OFF_CFG: rd_mux = cfg_reg;
      default: rd_mux = 8'h00;
    endcase
  end

  // one wait cycle per access
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      waitrequest_reg <= 1'b1;
      readdata_reg <= 32'h0;
    end else begin
      if (waitrequest_reg && (avs_read || avs_write)) begin
        waitrequest_reg <= 1'b0;
        readdata_reg <= {24'h0, rd_mux};
      end else begin
        waitrequest_reg <= 1'b1;
      end
    end
  end

  assign avs_readdata = readdata_reg;
  assign avs_waitrequest = waitrequest_reg;

  // interrupt output, each event gated by its enable
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= sr_ok && |(event_reg & irq_en_reg);
    end
  end
  assign irq = irq_reg;

  AST_DMO_IRQ: assert property (@(posedge clock) disable iff (rst)
    (event_set[lei_pkg::BIT_DMO] && irq_en_reg[lei_pkg::BIT_DMO]) ##1
    (sr_ok && irq_en_reg[lei_pkg::BIT_DMO]) |=> irq_reg)
    else $error("driver monitor change did not interrupt");
  AST_FLS_IRQ: assert property (@(posedge clock) disable iff (rst)
    (event_set[lei_pkg::BIT_FLS] && irq_en_reg[lei_pkg::BIT_FLS]) ##1
    (sr_ok && irq_en_reg[lei_pkg::BIT_FLS]) |=> irq_reg)
    else $error("fifo limit did not interrupt");
  AST_LCV_MASK: assert property (@(posedge clock) disable iff (rst)
    (event_reg == 8'h10 && !irq_en_reg[lei_pkg::BIT_LCV]) |=> !irq_reg)
    else $error("masked violation interrupted");
  AST_LOOP_CODE_DETECTED_IRQ: assert property (@(posedge clock) disable iff (rst)
    $fell(loop_code_detected) && sr_ok && irq_en_reg[lei_pkg::BIT_LOOP_CODE_DETECTED]
    ##1 (sr_ok && irq_en_reg[lei_pkg::BIT_LOOP_CODE_DETECTED]) |=> irq_reg)
    else $error("loop code loss did not interrupt");
  AST_AIS_MASK: assert property (@(posedge clock) disable iff (rst)
    (event_reg == 8'h04 && !irq_en_reg[lei_pkg::BIT_AIS]) |=> !irq_reg)
    else $error("masked ais interrupted");
  AST_SR_GATE: assert property (@(posedge clock) disable iff (rst)
    !sr_ok |=> !irq_reg && (event_reg & ~$past(event_reg)) == 8'h00)
    else $error("interrupt outside single-rail operation");
  AST_EV_STICKY: assert property (@(posedge clock) disable iff (rst)
    (|event_set) |=> ((event_reg & $past(event_set)) == $past(event_set)))
    else $error("event lost against clear");
  AST_LCV_IRQ: assert property (@(posedge clock) disable iff (rst)
    (event_set[lei_pkg::BIT_LCV] && irq_en_reg[lei_pkg::BIT_LCV]) ##1
    (sr_ok && irq_en_reg[lei_pkg::BIT_LCV]) |=> irq_reg)
    else $error("enabled violation did not interrupt");
  AST_AIS_IRQ: assert property (@(posedge clock) disable iff (rst)
    (event_set[lei_pkg::BIT_AIS] && irq_en_reg[lei_pkg::BIT_AIS]) ##1
    (sr_ok && irq_en_reg[lei_pkg::BIT_AIS]) |=> irq_reg)
    else $error("enabled ais did not interrupt");
  AST_LOOP_CODE_DETECTED_START: assert property (@(posedge clock) disable iff (rst)
    $rose(loop_code_detected) && sr_ok && irq_en_reg[lei_pkg::BIT_LOOP_CODE_DETECTED]
    ##1 (sr_ok && irq_en_reg[lei_pkg::BIT_LOOP_CODE_DETECTED]) |=> irq_reg)
    else $error("loop code start did not interrupt");
  AST_FLS_MASK: assert property (@(posedge clock) disable iff (rst)
    (event_reg == 8'h20 && !irq_en_reg[lei_pkg::BIT_FLS]) |=> !irq_reg)
    else $error("masked fifo limit interrupted");
  AST_DMO_MASK: assert property (@(posedge clock) disable iff (rst)
    (event_reg == 8'h40 && !irq_en_reg[lei_pkg::BIT_DMO]) |=> !irq_reg)
    else $error("masked driver monitor interrupted");
  AST_LOOP_CODE_DETECTED_MASK: assert property (@(posedge clock) disable iff (rst)
    (event_reg == 8'h08 && !irq_en_reg[lei_pkg::BIT_LOOP_CODE_DETECTED]) |=> !irq_reg)
    else $error("masked loop code interrupted");
  AST_EN_GATE: assert property (@(posedge clock) disable iff (rst)
    ((event_reg & irq_en_reg) == 8'h00) |=> !irq_reg)
    else $error("interrupt without an enabled event");
  AST_EN_UNUSED: assert property (@(posedge clock) disable iff (rst)
    (irq_en_reg & ~lei_pkg::IRQ_MASK) == 8'h00)
    else $error("unused enable bit set");
  AST_EV_HOLD: assert property (@(posedge clock) disable iff (rst)
    !(wr_go && avs_address == lei_pkg::OFF_EVENT) |=>
    (($past(event_reg) & ~event_reg) == 8'h00))
    else $error("event bit dropped without a clear");
  COV_LOOP: cover property (@(posedge clock) disable iff (rst)
    $rose(loop_code_detected) && sr_ok);
  COV_IRQ: cover property (@(posedge clock) disable iff (rst) $rose(irq_reg));
  COV_CLEAR: cover property (@(posedge clock) disable iff (rst)
    wr_go && avs_address == lei_pkg::OFF_EVENT && (|event_reg));
endmodule : lei_top

// File: tb/lei_line_model.sv
// far side line model: tx and rx line clocks, tx data, rx loop codes
// assumes pins are sampled asynchronously by the slice under test
`timescale 1ns/1ns
module lei_line_model (
  // transmit line
  output logic tx_line_clock,
  output logic tx_data_in,
  input wire logic tx_pos,
  input wire logic tx_neg,
  // receive line
  output logic rx_line_clock,
  output logic rx_data,
  // scenario controls
  input wire logic tx_ones,
  input wire logic loop_on,
  input wire logic loop_dn,
  output int viol_count
);
  logic last_pos;
  int idx;
  int len;

  // free running line clocks, unrelated in phase to the system clock
  initial begin
    tx_line_clock = 1'b0;
    tx_data_in = 1'b1;
    viol_count = 0;
    last_pos = 1'b0;
    #7;
    forever #200 tx_line_clock = ~tx_line_clock;
  end

  initial begin
    rx_line_clock = 1'b0;
    rx_data = 1'b1;
    idx = 0;
    #113;
    forever #200 rx_line_clock = ~rx_line_clock;
  end

  always @(negedge tx_line_clock) begin
    tx_data_in <= tx_ones;
  end

  // two marks of one polarity in a row count as a violation
  always @(posedge tx_line_clock) begin
    if (tx_pos || tx_neg) begin
      if (tx_pos == last_pos) viol_count <= viol_count + 1;
      last_pos <= tx_pos;
    end
  end

  // loop up 00001, loop down 001, otherwise all ones
  assign len = loop_dn ? 3 : 5;
  always @(negedge rx_line_clock) begin
    rx_data <= loop_on ? (idx >= len - 1) : 1'b1;
    idx <= (idx >= len - 1) ? 0 : idx + 1;
  end
endmodule : lei_line_model

// File: tb/liu_error_insert_irq_enable_test.sv
// self-checking bench for the error insert and interrupt enable slice
// assumes lei_top with avalon-mm slave and the line model on its pins
`timescale 1ns/1ns
`define CHK(nm, ex, gt) begin num_checks++; if ((gt) !== (ex)) begin \
  mismatches++; $display("mismatch %s expected %h seen %h", nm, ex, gt); \
  end end
module liu_error_insert_irq_enable_test;
  logic clock;
  logic rst;
  logic [7:0] avs_address;
  logic avs_read;
  logic avs_write;
  logic [3:0] avs_byteenable;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic tx_line_clock, tx_data_in, rx_line_clock, rx_data;
  logic tx_pos, tx_neg, irq;
  logic [2:0] alarm;
  logic tx_ones, loop_on, loop_dn;
  int viol_count;
  int mismatches = 0;
  int num_checks = 0;
  int cycles = 0;
  int base;
  int bits[3] = '{lei_pkg::BIT_FLS, lei_pkg::BIT_LCV, lei_pkg::BIT_AIS};

  lei_top #(.LOOP_CYCLES(50)) DUT (.clock(clock), .rst(rst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .tx_line_clock(tx_line_clock), .tx_data_in(tx_data_in),
    .rx_line_clock(rx_line_clock), .rx_data(rx_data), .tx_pos(tx_pos),
    .tx_neg(tx_neg), .fifo_limit_in(alarm[0]),
    .line_violation_in(alarm[1]), .ais_detect_in(alarm[2]), .irq(irq));

  lei_line_model line (.tx_line_clock(tx_line_clock),
    .tx_data_in(tx_data_in), .tx_pos(tx_pos), .tx_neg(tx_neg),
    .rx_line_clock(rx_line_clock), .rx_data(rx_data), .tx_ones(tx_ones),
    .loop_on(loop_on), .loop_dn(loop_dn), .viol_count(viol_count));

  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  task automatic results;
    if (mismatches == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : results

  always @(posedge clock) begin
    cycles++;
    if (cycles == 30000) begin
      mismatches++;
      results();
    end
  end

  // one avalon access, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clock);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do begin
      @(posedge clock);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    if (n >= 50) mismatches++;
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input string nm);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    `CHK(nm, e, q)
  endtask : rd

  // zero first, then the insert bit, then let the line run
  task automatic insert(input logic [31:0] v);
    wr(lei_pkg::OFF_INSERT, 32'h0);
    repeat (30) @(posedge clock);
    wr(lei_pkg::OFF_INSERT, v);
    repeat (100) @(posedge clock);
  endtask : insert

  initial begin
    rst = 1'b1;
    avs_address = 8'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_byteenable = 4'hf;
    avs_writedata = 32'h0;
    alarm = 3'h0;
    tx_ones = 1'b1;
    loop_on = 1'b0;
    loop_dn = 1'b0;
    repeat (8) @(posedge clock);
    rst <= 1'b0;
    rd(lei_pkg::OFF_INSERT, 32'h0, "insert reset");
    rd(lei_pkg::OFF_IRQ_EN, 32'h0, "enable reset");
    rd(lei_pkg::OFF_CFG, 32'h0, "cfg reset");
    rd(8'h20, 32'h0, "unmapped");
    wr(lei_pkg::OFF_IRQ_EN, 32'hff);
    rd(lei_pkg::OFF_IRQ_EN, 32'h7c, "enable bits");
    // framer side not single-rail: nothing recorded
    wr(lei_pkg::OFF_CFG, 32'h08);
    alarm[2] <= 1'b1;
    repeat (5) @(posedge clock);
    `CHK("irq no single rail", 1'b0, irq)
    rd(lei_pkg::OFF_EVENT, 32'h0, "event no single rail");
    alarm[2] <= 1'b0;
    wr(lei_pkg::OFF_CFG, 32'h18);
    // level alarms: masked, then allowed, then cleared
    foreach (bits[i]) begin
      wr(lei_pkg::OFF_IRQ_EN, 32'h0);
      alarm[i] <= 1'b1;
      repeat (5) @(posedge clock);
      `CHK("irq masked", 1'b0, irq)
      rd(lei_pkg::OFF_EVENT, 32'h1 << bits[i], "event set");
      wr(lei_pkg::OFF_IRQ_EN, 32'h1 << bits[i]);
      repeat (3) @(posedge clock);
      `CHK("irq enabled", 1'b1, irq)
      wr(lei_pkg::OFF_EVENT, 32'h1 << bits[i]);
      alarm[i] <= 1'b0;
      repeat (3) @(posedge clock);
      `CHK("irq cleared", 1'b0, irq)
    end
    // driver monitor: 128 idle bits set the alarm, a mark clears it
    wr(lei_pkg::OFF_IRQ_EN, 32'h40);
    tx_ones <= 1'b0;
    repeat (1150) @(posedge clock);
    rd(lei_pkg::OFF_LIVE, 32'h0, "monitor early");
    repeat (250) @(posedge clock);
    rd(lei_pkg::OFF_LIVE, 32'h40, "monitor set");
    `CHK("irq monitor set", 1'b1, irq)
    wr(lei_pkg::OFF_EVENT, 32'h40);
    tx_ones <= 1'b1;
    repeat (60) @(posedge clock);
    rd(lei_pkg::OFF_LIVE, 32'h0, "monitor clear");
    rd(lei_pkg::OFF_EVENT, 32'h40, "monitor fall event");
    wr(lei_pkg::OFF_EVENT, 32'h40);
    // violations in single-rail data, no repeat without a new rise
    base = viol_count;
    insert(32'h4);
    `CHK("one violation", base + 1, viol_count)
    wr(lei_pkg::OFF_INSERT, 32'h4);
    repeat (100) @(posedge clock);
    `CHK("no rise no violation", base + 1, viol_count)
    wr(lei_pkg::OFF_CFG, 32'h1c);
    insert(32'h4);
    // fresh qrss opens with a long zero run, the violation waits for a mark
    repeat (100) @(posedge clock);
    `CHK("qrss violation", base + 2, viol_count)
    insert(32'h2);
    `CHK("bit error no violation", base + 2, viol_count)
    rd(lei_pkg::OFF_INSERT, 32'h2, "insert readback");
    // loop up then loop down code, start interrupts and stop sets its event
    wr(lei_pkg::OFF_IRQ_EN, 32'h08);
    for (int m = 0; m < 2; m++) begin
      wr(lei_pkg::OFF_CFG, m ? 32'h38 : 32'h18);
      wr(lei_pkg::OFF_EVENT, 32'h7c);
      loop_dn <= m[0];
      loop_on <= 1'b1;
      repeat (700) @(posedge clock);
      rd(lei_pkg::OFF_LIVE, 32'h08, "loop live");
      `CHK("irq loop start", 1'b1, irq)
      wr(lei_pkg::OFF_EVENT, 32'h08);
      loop_on <= 1'b0;
      repeat (100) @(posedge clock);
      rd(lei_pkg::OFF_EVENT, 32'h08, "loop stop event");
      rd(lei_pkg::OFF_LIVE, 32'h0, "loop live off");
    end
    results();
  end
endmodule : liu_error_insert_irq_enable_test
